// File: pts_params.svh
// offsets, field positions and reset values of the translation mode selector
`ifndef PTS_PARAMS_SVH
`define PTS_PARAMS_SVH

`define PTS_ADDR_W 6
`define PTS_OFS_CW0 6'h00
`define PTS_OFS_CW4 6'h04
`define PTS_OFS_EFR 6'h08
`define PTS_OFS_MODE 6'h0C
`define PTS_OFS_DIR 6'h10
`define PTS_OFS_PTR 6'h14
`define PTS_OFS_WALK 6'h18
`define PTS_OFS_VA_LO 6'h1C
`define PTS_OFS_VA_HI 6'h20
`define PTS_OFS_OFFSET 6'h24
`define PTS_OFS_PASS 6'h28

`define PTS_CW0_TE_BIT 31
`define PTS_CW4_AEE_BIT 5
`define PTS_CW4_LPE_BIT 4
`define PTS_CW4_FIVE_BIT 12
`define PTS_EFR_LME_BIT 8
`define PTS_EFR_LACT_BIT 10
`define PTS_ENTRY_SIZE_BIT 7

`define PTS_RST_TE 1'h0
`define PTS_RST_AEE 1'h0
`define PTS_RST_LPE 1'h0
`define PTS_RST_FIVE 1'h0
`define PTS_RST_LME 1'h0
`define PTS_RST_WORD 32'h0000_0000

`define PTS_VA_LEGACY 7'h20
`define PTS_VA_LONG 7'h30
`define PTS_PA_BASE 7'h20
`define PTS_PA_LARGE 7'h28
`define PTS_PA_EXT 7'h34
`define PTS_OFF_4K 5'h0C
`define PTS_OFF_2M 5'h15
`define PTS_OFF_4M 5'h16
`define PTS_OFF_1G 5'h1E

`endif

// File: pts_pkg.sv
// types shared by the translation mode selector
package pts_pkg;

  typedef enum logic [1:0]
  {
    PTS_4K = 2'b00,
    PTS_2M = 2'b01,
    PTS_4M = 2'b10,
    PTS_1G = 2'b11
  } pts_size_type;

  typedef enum logic [2:0]
  {
    LVL_NONE = 3'b000,
    LVL_TABLE = 3'b001,
    LVL_DIR = 3'b010,
    LVL_PTR = 3'b011,
    LVL_MAP4 = 3'b100,
    LVL_MAP5 = 3'b101
  } pts_level_type;

endpackage

// File: pts_mode_dec.sv
// decodes the control bits into the active translation mode
`timescale 1ns/1ps
`include "pts_params.svh"
module pts_mode_dec
(
  input wire logic translation_enable,
  input wire logic address_extension_enable,
  input wire logic large_page_enable,
  input wire logic long_enable,
  input wire logic five_level_enable,
  output logic long_mode_active,
  output logic entry_64,
  output logic [6:0] va_bits,
  output pts_pkg::pts_size_type large_size,
  output pts_pkg::pts_level_type top_level
);
  import pts_pkg::*;

  always_comb
  begin
    // long operation follows translation_enable once long and extension are enabled
    long_mode_active = long_enable & translation_enable & address_extension_enable;
    entry_64 = address_extension_enable;
    va_bits = long_mode_active ? `PTS_VA_LONG : `PTS_VA_LEGACY;
    if (address_extension_enable)
      large_size = PTS_2M;
    else if (large_page_enable)
      large_size = PTS_4M;
    else
      large_size = PTS_4K;
    if (!translation_enable)
      top_level = LVL_NONE;
    else if (long_mode_active)
      top_level = five_level_enable ? LVL_MAP5 : LVL_MAP4;
    else
      top_level = address_extension_enable ? LVL_PTR : LVL_DIR;
  end

endmodule

// File: pts_walk_res.sv
// works out where a walk ends and the resulting page size
`timescale 1ns/1ps
`include "pts_params.svh"
module pts_walk_res
(
  input wire logic translation_enable,
  input wire logic long_mode_active,
  input wire logic address_extension_enable,
  input wire pts_pkg::pts_size_type large_size,
  input wire logic ptr_size_sel,
  input wire logic dir_size_sel,
  input wire logic [31:0] va_lo,
  output pts_pkg::pts_level_type end_level,
  output pts_pkg::pts_size_type page_size,
  output logic [6:0] pa_bits,
  output logic [4:0] offset_bits,
  output logic [31:0] page_offset
);
  import pts_pkg::*;

  function automatic logic [4:0] size_to_bits(input pts_size_type s);
    case (s)
      PTS_2M: size_to_bits = `PTS_OFF_2M;
      PTS_4M: size_to_bits = `PTS_OFF_4M;
      PTS_1G: size_to_bits = `PTS_OFF_1G;
      default: size_to_bits = `PTS_OFF_4K;
    endcase
  endfunction

  always_comb
  begin
    if (!translation_enable)
    begin
      end_level = LVL_NONE;
      page_size = PTS_4K;
    end
    else if (long_mode_active && ptr_size_sel)
    begin
      end_level = LVL_PTR;
      page_size = PTS_1G;
    end
    else if (dir_size_sel && large_size != PTS_4K)
    begin
      end_level = LVL_DIR;
      page_size = large_size;
    end
    else
    begin
      end_level = LVL_TABLE;
      page_size = PTS_4K;
    end
    if (address_extension_enable)
      pa_bits = `PTS_PA_EXT;
    else if (translation_enable && page_size == PTS_4M)
      pa_bits = `PTS_PA_LARGE;
    else
      pa_bits = `PTS_PA_BASE;
    offset_bits = size_to_bits(page_size);
    // lowest field is the byte offset within the page
    page_offset = va_lo & ((32'h0000_0001 << offset_bits) - 32'h0000_0001);
  end

endmodule

// File: pts_mode_sel.sv
// translation mode selector with its avalon register slave
// Operation
// - translation_enable, bit 31 of control_word_0, turns translation on or off.
// - address_extension_enable, bit 5 of control_word_4, enables extended physical addressing.
// - with address extension, table entries are 64 bits instead of 32.
// - with address extension, physical addresses reach 52 bits, legacy or long.
// - large_page_enable, bit 4 of control_word_4, permits large pages.
// - address extension on gives 2 Mbyte large pages regardless of large_page_enable.
// - extension off, large_page_enable on gives 4 Mbyte large pages.
// - extension and large_page_enable both off give only 4 Kbyte pages.
// - in long operation large_page_enable is ignored; 4 Kbyte and 2 Mbyte directory pages.
// - legacy 4 Mbyte pages map 32-bit virtual to 40-bit physical with 32-bit entries.
// - bit 7 of a directory_entry selects 4 Kbyte or large page.
// - directory page_size_select one ends the walk at the directory with a large page.
// - directory page_size_select zero uses 4 Kbyte pages ending at the table_entry.
// - long operation pointer entry with page_size_select one maps 1 Gbyte, ends walk.
// - long supports 4K, 2M, 1G; legacy supports 4K, 2M, 4M pages.
// - long operation maps 48-bit virtual to up to 52-bit physical addresses.
// - virtual address splits into table indices; lowest field is the byte offset.
// - fifth level only with five-level enabled; legacy drops level four, maybe pointer.
// - page size is chosen per directory_entry so sizes coexist.
// - with long enabled, translation_enable toggles long_mode_active; here only while address_extension_enable is set too.
// - no large pages or select zero means the directory points to a table.
//
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`include "pts_params.svh"
module pts_mode_sel
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic translation_active,
  output logic long_mode_active,
  output logic entry_64,
  output pts_pkg::pts_size_type large_size,
  output pts_pkg::pts_level_type walk_end_level,
  output pts_pkg::pts_size_type walk_page_size
);
  import pts_pkg::*;

  typedef struct packed
  {
    logic te;
    logic aee;
    logic lpe;
    logic five;
    logic lme;
    logic [31:0] dir_entry;
    logic [31:0] ptr_entry;
    logic [31:0] va_lo;
    logic [15:0] va_hi;
    logic [31:0] readdata;
    logic waitreq;
    logic tr_active;
    logic long_act;
    logic entry_64;
    pts_size_type large_size;
    pts_level_type end_level;
    pts_size_type page_size;
  } pts_state_type;

  pts_state_type st;
  pts_state_type next_st;

  logic dec_long_act;
  logic dec_entry_64;
  logic [6:0] dec_va_bits;
  pts_size_type dec_large_size;
  pts_level_type dec_top_level;
  pts_level_type res_end_level;
  pts_size_type res_page_size;
  logic [6:0] res_pa_bits;
  logic [4:0] res_offset_bits;
  logic [31:0] res_page_offset;

  function automatic logic [31:0] merge_lanes(input logic [31:0] old_word, input logic [31:0] new_word,
    input logic [3:0] lanes);
    logic [31:0] m;
    m = old_word;
    for (int i = 0; i < 4; i++)
    begin
      if (lanes[i])
        m[i*8 +: 8] = new_word[i*8 +: 8];
    end
    merge_lanes = m;
  endfunction

  pts_mode_dec u_mode_dec
  (
    .translation_enable(st.te),
    .address_extension_enable(st.aee),
    .large_page_enable(st.lpe),
    .long_enable(st.lme),
    .five_level_enable(st.five),
    .long_mode_active(dec_long_act),
    .entry_64(dec_entry_64),
    .va_bits(dec_va_bits),
    .large_size(dec_large_size),
    .top_level(dec_top_level)
  );

  pts_walk_res u_walk_res
  (
    .translation_enable(st.te),
    .long_mode_active(dec_long_act),
    .address_extension_enable(st.aee),
    .large_size(dec_large_size),
    .ptr_size_sel(st.ptr_entry[`PTS_ENTRY_SIZE_BIT]),
    .dir_size_sel(st.dir_entry[`PTS_ENTRY_SIZE_BIT]),
    .va_lo(st.va_lo),
    .end_level(res_end_level),
    .page_size(res_page_size),
    .pa_bits(res_pa_bits),
    .offset_bits(res_offset_bits),
    .page_offset(res_page_offset)
  );

  always_comb
  begin
    logic [31:0] rd;
    logic [31:0] wr;
    rd = 32'h0000_0000;
    wr = 32'h0000_0000;
    next_st = st;
    case (avs_address)
      `PTS_OFS_CW0: rd[`PTS_CW0_TE_BIT] = st.te;
      `PTS_OFS_CW4:
      begin
        rd[`PTS_CW4_AEE_BIT] = st.aee;
        rd[`PTS_CW4_LPE_BIT] = st.lpe;
        rd[`PTS_CW4_FIVE_BIT] = st.five;
      end
      `PTS_OFS_EFR:
      begin
        rd[`PTS_EFR_LME_BIT] = st.lme;
        rd[`PTS_EFR_LACT_BIT] = dec_long_act;
      end
      `PTS_OFS_MODE:
      begin
        rd[0] = st.te;
        rd[1] = dec_long_act;
        rd[2] = dec_entry_64;
        rd[10:4] = dec_va_bits;
        rd[21:20] = dec_large_size;
        rd[26:24] = dec_top_level;
      end
      `PTS_OFS_DIR: rd = st.dir_entry;
      `PTS_OFS_PTR: rd = st.ptr_entry;
      `PTS_OFS_WALK:
      begin
        rd[2:0] = res_end_level;
        rd[5:4] = res_page_size;
        rd[14:8] = res_pa_bits;
        rd[20:16] = res_offset_bits;
      end
      `PTS_OFS_VA_LO: rd = st.va_lo;
      `PTS_OFS_VA_HI: rd[15:0] = st.va_hi;
      `PTS_OFS_OFFSET: rd = res_page_offset;
      `PTS_OFS_PASS: rd = st.te ? 32'h0000_0000 : st.va_lo;
      default: rd = 32'h0000_0000;
    endcase
    wr = merge_lanes(rd, avs_writedata, avs_byteenable);
    // one wait cycle, then the request is taken at the edge that sees waitrequest low
    if (st.waitreq && (avs_read || avs_write))
    begin
      next_st.waitreq = 1'b0;
      next_st.readdata = avs_read ? rd : 32'h0000_0000;
    end
    else if (!st.waitreq)
    begin
      next_st.waitreq = 1'b1;
      if (avs_write)
      begin
        case (avs_address)
          `PTS_OFS_CW0: next_st.te = wr[`PTS_CW0_TE_BIT];
          `PTS_OFS_CW4:
          begin
            next_st.aee = wr[`PTS_CW4_AEE_BIT];
            next_st.lpe = wr[`PTS_CW4_LPE_BIT];
            next_st.five = wr[`PTS_CW4_FIVE_BIT];
          end
          `PTS_OFS_EFR: next_st.lme = wr[`PTS_EFR_LME_BIT];
          `PTS_OFS_DIR: next_st.dir_entry = wr;
          `PTS_OFS_PTR: next_st.ptr_entry = wr;
          `PTS_OFS_VA_LO: next_st.va_lo = wr;
          `PTS_OFS_VA_HI: next_st.va_hi = wr[15:0];
          default: next_st.va_hi = st.va_hi;
        endcase
      end
    end
    next_st.tr_active = st.te;
    next_st.long_act = dec_long_act;
    next_st.entry_64 = dec_entry_64;
    next_st.large_size = dec_large_size;
    next_st.end_level = res_end_level;
    next_st.page_size = res_page_size;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.te <= `PTS_RST_TE;
      st.aee <= `PTS_RST_AEE;
      st.lpe <= `PTS_RST_LPE;
      st.five <= `PTS_RST_FIVE;
      st.lme <= `PTS_RST_LME;
      st.dir_entry <= `PTS_RST_WORD;
      st.ptr_entry <= `PTS_RST_WORD;
      st.waitreq <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign avs_readdata = st.readdata;
  assign avs_waitrequest = st.waitreq;
  assign translation_active = st.tr_active;
  assign long_mode_active = st.long_act;
  assign entry_64 = st.entry_64;
  assign large_size = st.large_size;
  assign walk_end_level = st.end_level;
  assign walk_page_size = st.page_size;

  AST_TE_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    avs_write && !avs_waitrequest && avs_address == `PTS_OFS_CW0 && avs_byteenable[3]
    |=> ##1 translation_active == $past(avs_writedata[31], 2))
    else $error("translation enable did not follow write");

  AST_LONG_CAUSE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    long_mode_active |-> $past(st.te) && $past(st.aee) && $past(st.lme))
    else $error("long mode active without its enables");

  AST_LONG_SET: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st.te && st.aee && st.lme |=> long_mode_active)
    else $error("long mode not activated");

  AST_ENTRY_WIDE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(st.aee) |-> entry_64)
    else $error("entries not 64 bits with extension");

  AST_LARGE_2M: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st.aee |=> large_size == PTS_2M)
    else $error("large page not 2 Mbyte with extension");

  AST_LARGE_4M: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !st.aee && st.lpe |=> large_size == PTS_4M)
    else $error("large page not 4 Mbyte");

  AST_ONLY_4K: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !st.aee && !st.lpe |=> walk_page_size == PTS_4K)
    else $error("large page used with no large pages");

  AST_OFF_NO_WALK: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !st.te |=> walk_end_level == LVL_NONE && !long_mode_active)
    else $error("walk reported with translation off");

  AST_PTR_1G: assert property (@(posedge clk_sys) disable iff (!rst_n)
    dec_long_act && st.ptr_entry[`PTS_ENTRY_SIZE_BIT]
    |=> walk_end_level == LVL_PTR && walk_page_size == PTS_1G)
    else $error("1 Gbyte page did not end walk");

  AST_DIR_LARGE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st.te && !(dec_long_act && st.ptr_entry[`PTS_ENTRY_SIZE_BIT]) && st.dir_entry[`PTS_ENTRY_SIZE_BIT]
    && (st.aee || st.lpe) |=> walk_end_level == LVL_DIR && walk_page_size == large_size)
    else $error("large page did not end walk at directory");

  AST_DIR_SMALL: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st.te && !(dec_long_act && st.ptr_entry[`PTS_ENTRY_SIZE_BIT]) && !st.dir_entry[`PTS_ENTRY_SIZE_BIT]
    |=> walk_end_level == LVL_TABLE && walk_page_size == PTS_4K)
    else $error("small page did not end at table");

  AST_BUS_ANSWER: assert property (@(posedge clk_sys) disable iff (!rst_n)
    avs_waitrequest && (avs_read || avs_write) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("request not answered in one cycle");

  AST_TE_LANE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    avs_write && !avs_waitrequest && avs_address == `PTS_OFS_CW0 && !avs_byteenable[3] |=> $stable(st.te))
    else $error("translation enable changed with its lane off");

  AST_AEE_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    avs_write && !avs_waitrequest && avs_address == `PTS_OFS_CW4 && avs_byteenable[0]
    |=> st.aee == $past(avs_writedata[`PTS_CW4_AEE_BIT]))
    else $error("extension enable did not follow write");

  AST_LPE_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    avs_write && !avs_waitrequest && avs_address == `PTS_OFS_CW4 && avs_byteenable[0]
    |=> st.lpe == $past(avs_writedata[`PTS_CW4_LPE_BIT]))
    else $error("large page enable did not follow write");

  AST_ENTRY_NARROW: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !st.aee |=> !entry_64)
    else $error("entries wide without extension");

  AST_EXT_PA: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st.aee |-> res_pa_bits == `PTS_PA_EXT)
    else $error("physical width not extended");

  AST_LARGE_NONE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !st.aee && !st.lpe |=> large_size == PTS_4K)
    else $error("large page size reported with large pages off");

  AST_LONG_NO_4M: assert property (@(posedge clk_sys) disable iff (!rst_n)
    long_mode_active |-> large_size == PTS_2M && walk_page_size != PTS_4M)
    else $error("4 Mbyte page in long operation");

  AST_LEGACY_40: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st.te && !st.aee && st.lpe && st.dir_entry[`PTS_ENTRY_SIZE_BIT]
    |-> res_pa_bits == `PTS_PA_LARGE && res_offset_bits == `PTS_OFF_4M)
    else $error("legacy large page not 40 bit physical");

  AST_LEGACY_NO_1G: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !long_mode_active |-> walk_page_size != PTS_1G)
    else $error("1 Gbyte page outside long operation");

  AST_LONG_VA: assert property (@(posedge clk_sys) disable iff (!rst_n)
    dec_long_act |-> dec_va_bits == `PTS_VA_LONG && res_pa_bits == `PTS_PA_EXT)
    else $error("long operation address widths wrong");

  AST_OFFSET_4K: assert property (@(posedge clk_sys) disable iff (!rst_n)
    res_page_size == PTS_4K
    |-> res_page_offset[31:12] == 20'h0_0000 && res_page_offset[11:0] == st.va_lo[11:0])
    else $error("small page offset wrong");

  AST_TOP_NO_EXT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st.te && !st.aee |-> dec_top_level == LVL_DIR)
    else $error("legacy walk without extension not rooted at directory");

  AST_TOP_LONG: assert property (@(posedge clk_sys) disable iff (!rst_n)
    dec_long_act |-> dec_top_level == (st.five ? LVL_MAP5 : LVL_MAP4))
    else $error("long operation top level wrong");

  AST_NO_LARGE_TABLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st.te && !st.aee && !st.lpe |=> walk_end_level == LVL_TABLE)
    else $error("directory did not point to a table");

  AST_PASS_READ: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !st.te && avs_read && avs_waitrequest && avs_address == `PTS_OFS_PASS
    |=> avs_readdata == $past(st.va_lo))
    else $error("address not passed through with translation off");

  AST_BUS_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    avs_waitrequest && !avs_read && !avs_write |=> avs_waitrequest)
    else $error("waitrequest dropped with no request");

  AST_WRITE_NO_DATA: assert property (@(posedge clk_sys) disable iff (!rst_n)
    avs_write && avs_waitrequest |=> avs_readdata == 32'h0000_0000)
    else $error("write returned read data");

endmodule

// File: tb_top.sv
// self-checking bench for the translation mode selector
`timescale 1ns/1ps
module tb_top;
  import pts_pkg::*;

  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic translation_active;
  logic long_mode_active;
  logic entry_64;
  pts_size_type large_size;
  pts_level_type walk_end_level;
  pts_size_type walk_page_size;
  int failures = 0;
  int check_count = 0;

  always #2 clk_sys = ~clk_sys;

  pts_mode_sel pts_mode_sel_i
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .translation_active(translation_active),
    .long_mode_active(long_mode_active),
    .entry_64(entry_64),
    .large_size(large_size),
    .walk_end_level(walk_end_level),
    .walk_page_size(walk_page_size)
  );

  task automatic finish_test();
    if (failures == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    int n;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50)
    begin
      failures++;
      finish_test();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hf, q);
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, 4'hf, q);
    chk(q, exp);
  endtask

  // rows: {te, aee, lpe, lme, five, dir ps, ptr ps}
  logic [6:0] rows [10] = '{7'h03, 7'h42, 7'h52, 7'h50, 7'h63, 7'h70, 7'h7a, 7'h6d, 7'h29, 7'h68};

  initial
  begin
    logic te, aee, lpe, lme, five, dps, pps, lact;
    logic [31:0] lvl, sz, off, pa, lg, top, va, q;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk({31'h0, translation_active}, 32'h0000_0000);
    chk({29'h0, walk_end_level}, 32'h0000_0000);
    rd_chk(6'h00, 32'h0000_0000);
    rd_chk(6'h04, 32'h0000_0000);
    rd_chk(6'h08, 32'h0000_0000);
    wr(6'h2c, 32'hffff_ffff);
    rd_chk(6'h2c, 32'h0000_0000);
    wr(6'h28, 32'hffff_ffff);
    rd_chk(6'h28, 32'h0000_0000);
    // byte lane 3 off: enable bit must not land
    bus(1'b1, 6'h00, 32'h8000_0000, 4'h7, q);
    rd_chk(6'h00, 32'h0000_0000);
    wr(6'h20, 32'h1234_5678);
    rd_chk(6'h20, 32'h0000_5678);
    wr(6'h1c, 32'hdead_beef);
    foreach (rows[i])
    begin
      {te, aee, lpe, lme, five, dps, pps} = rows[i];
      // extension is set ahead of long enable
      wr(6'h04, {19'h0, five, 6'h0, aee, lpe, 4'h0});
      wr(6'h08, {23'h0, lme, 8'h0});
      wr(6'h10, {24'h0, dps, 7'h0});
      wr(6'h14, {24'h0, pps, 7'h0});
      wr(6'h00, {te, 31'h0});
      repeat (2) @(posedge clk_sys);
      lact = te & aee & lme;
      lg = aee ? 32'h1 : (lpe ? 32'h2 : 32'h0);
      if (lact && pps)
        {lvl, sz, off, pa} = {32'h3, 32'h3, 32'h1e, 32'h34};
      else if (dps && (aee || lpe))
        {lvl, sz, off, pa} = {32'h2, lg, aee ? 32'h15 : 32'h16, aee ? 32'h34 : 32'h28};
      else
        {lvl, sz, off, pa} = {32'h1, 32'h0, 32'h0c, aee ? 32'h34 : 32'h20};
      top = lact ? (five ? 32'h5 : 32'h4) : (aee ? 32'h3 : 32'h2);
      va = lact ? 32'h30 : 32'h20;
      chk({31'h0, translation_active}, {31'h0, te});
      chk({31'h0, entry_64}, {31'h0, aee});
      chk({31'h0, long_mode_active}, {31'h0, lact});
      rd_chk(6'h08, {21'h0, lact, 1'b0, lme, 8'h0});
      if (!te)
      begin
        chk({29'h0, walk_end_level}, 32'h0000_0000);
        chk({30'h0, walk_page_size}, 32'h0000_0000);
        rd_chk(6'h28, 32'hdead_beef);
      end
      else
      begin
        chk({30'h0, large_size}, lg);
        chk({29'h0, walk_end_level}, lvl);
        chk({30'h0, walk_page_size}, sz);
        rd_chk(6'h18, (off << 16) | (pa << 8) | (sz << 4) | lvl);
        rd_chk(6'h0c, (top << 24) | (lg << 20) | (va << 4) | (aee << 2) | (lact << 1) | 32'h1);
        rd_chk(6'h24, 32'hdead_beef & ((32'h0000_0001 << off) - 32'h0000_0001));
        rd_chk(6'h28, 32'h0000_0000);
      end
    end
    finish_test();
  end
endmodule
